/* File: ucc_chk_asserts.sv */
// checker: port relations of the uart channel control block
// assumes binding to ucc_top ports on one pclk domain
`timescale 1ns/100ps
`default_nettype none
module ucc_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire framing_err_event,
  input wire [7:0] port_one_pin_out,
  input wire [7:0] port_one_pin_oe,
  input wire [3:0] channel_enabled_status,
  input wire [3:0] channel_start_pulse,
  input wire [1:0] irq_level,
  input wire irq_level_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // committed write and its target
  wire wr = psel && penable && pwrite && pstrb[0];
  wire st = wr && paddr == 12'h018;
  a_dir_oe: assert property (wr && paddr == 12'h014 |=> port_one_pin_oe == ~$past(pwdata[7:0]))
    else $error("pin enable differs from direction");
  a_latch_out: assert property (wr && paddr == 12'h010 |=> port_one_pin_out == $past(pwdata[7:0]))
    else $error("pin level differs from latch");
  a_start_pulse: assert property (st |=> channel_start_pulse == $past(pwdata[3:0]))
    else $error("start pulse wrong");
  a_start_sets: assert property (st |=> (channel_enabled_status & $past(pwdata[3:0])) == $past(pwdata[3:0]))
    else $error("channel not enabled by start");
  a_enabled_hold: assert property (!st |=> $stable(channel_enabled_status))
    else $error("channel state moved without start");
  a_trig_read: assert property (psel && penable && !pwrite && (paddr == 12'h000 || paddr == 12'h018) |-> prdata == 0)
    else $error("trigger register read nonzero");
  a_level_idle: assert property (!irq_level_valid |-> irq_level == 2'h3)
    else $error("level not lowest when idle");
  a_frame_flag: assert property (framing_err_event ##1 !(psel && penable && pwrite && paddr == 12'h000)
    ##1 (psel && !penable && !pwrite && paddr == 12'h020) |=> prdata[2])
    else $error("framing flag not set");
  c_start: cover property (st);
  c_top_level: cover property (irq_level_valid && irq_level == 2'h0);
  c_frame: cover property (framing_err_event);
endmodule
`default_nettype wire

/* File: ucc_regs.vh */
// register offsets, field positions and reset values of the uart channel control block
// included by ucc_top.v; definitions only
`ifndef UCC_REGS_VH
`define UCC_REGS_VH

// byte offsets of the register words on apb
`define UCC_OFF_FLAG_CLEAR 12'h000
`define UCC_OFF_IRQ_MASK 12'h004
`define UCC_OFF_PRIO_LOW 12'h008
`define UCC_OFF_PRIO_HIGH 12'h00c
`define UCC_OFF_PORT_LATCH 12'h010
`define UCC_OFF_PORT_DIR 12'h014
`define UCC_OFF_CHAN_START 12'h018
`define UCC_OFF_IRQ_REQUEST 12'h01c
`define UCC_OFF_RX_STATUS 12'h020
`define UCC_OFF_CHAN_ENABLED 12'h024
`define UCC_OFF_EVT_STATUS 12'h028
`define UCC_OFF_EVT_MASK 12'h02c

// error flag and clear trigger positions
`define UCC_BIT_OVERRUN 0
`define UCC_BIT_PARITY 1
`define UCC_BIT_FRAMING 2

// interrupt source positions in request, mask and priority registers
`define UCC_BIT_TX_END 0
`define UCC_BIT_RX_END 1
`define UCC_BIT_RX_ERROR 2

// port pin positions
`define UCC_BIT_RX_PIN 1
`define UCC_BIT_TX_PIN 2

// reset values
`define UCC_RST_IRQ_MASK 8'hff
`define UCC_RST_PRIO 8'hff
`define UCC_RST_PORT_LATCH 8'h00
`define UCC_RST_PORT_DIR 8'hff
`define UCC_RST_EVT_MASK 8'h00

// number of serial channels
`define UCC_CHANNELS 4

`endif

/* File: ucc_remote.sv */
// remote uart side: sees our tx pin, echoes it on our rx pin
// assumes pin 2 is tx and pin 1 is rx; undriven lines pulled up
`timescale 1ns/100ps
`default_nettype none
module ucc_remote (
  input wire pclk,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  output logic [7:0] pin_in
);
  // tx wire level: our driver or the pull-up
  wire tx = pin_oe[2] ? pin_out[2] : 1'b1;
  initial pin_in = 8'hff;
  // echo our tx line back onto rx
  always @(posedge pclk) begin
    pin_in <= {5'h1f, tx, tx, 1'b1};
  end
endmodule
`default_nettype wire

/* File: ucc_top.v */
// uart channel control slice: error flag clear, channel start, irq request/mask/priority, port one pins
// assumes an apb master on pclk, error and end events as one-cycle pulses from the engine on pclk
`timescale 1ns/100ps
`default_nettype none
`include "ucc_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// sticky flag vector: each bit set by its event, dropped by its clear, set wins
module ucc_sticky #(
  parameter W = 1
) (
  input wire pclk,
  input wire presetn,
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  output reg [W-1:0] flag
);

  // an event in the cycle of a clear must survive it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= {W{1'b0}};
    end else begin
      flag <= set | (flag & ~clr);
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////////
// register slice seen by software over apb
module ucc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire framing_err_event,
  input wire parity_err_event,
  input wire overrun_err_event,
  input wire rx_end_event,
  input wire tx_end_event,
  input wire [7:0] port_one_pin_in,
  output wire [7:0] port_one_pin_out,
  output wire [7:0] port_one_pin_oe,
  output wire [7:0] port_one_pin_sync,
  output wire [3:0] channel_enabled_status,
  output wire [3:0] channel_start_pulse,
  output wire irq_out,
  output wire [1:0] irq_level,
  output wire irq_level_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire wr_en;
  wire rd_en;
  wire hit;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign hit = (paddr == `UCC_OFF_FLAG_CLEAR) ||
               (paddr == `UCC_OFF_IRQ_MASK) ||
               (paddr == `UCC_OFF_PRIO_LOW) ||
               (paddr == `UCC_OFF_PRIO_HIGH) ||
               (paddr == `UCC_OFF_PORT_LATCH) ||
               (paddr == `UCC_OFF_PORT_DIR) ||
               (paddr == `UCC_OFF_CHAN_START) ||
               (paddr == `UCC_OFF_IRQ_REQUEST) ||
               (paddr == `UCC_OFF_RX_STATUS) ||
               (paddr == `UCC_OFF_CHAN_ENABLED) ||
               (paddr == `UCC_OFF_EVT_STATUS) ||
               (paddr == `UCC_OFF_EVT_MASK);
  assign pslverr = psel & penable & ~hit;

  // write strobes per register, low byte lane carries every field
  wire wr_low;
  wire wr_clear;
  wire wr_mask;
  wire wr_prio_lo;
  wire wr_prio_hi;
  wire wr_latch;
  wire wr_dir;
  wire wr_start;
  wire wr_request;
  wire wr_evt_mask;
  assign wr_low = wr_en & pstrb[0];
  assign wr_clear = wr_low && (paddr == `UCC_OFF_FLAG_CLEAR);
  assign wr_mask = wr_low && (paddr == `UCC_OFF_IRQ_MASK);
  assign wr_prio_lo = wr_low && (paddr == `UCC_OFF_PRIO_LOW);
  assign wr_prio_hi = wr_low && (paddr == `UCC_OFF_PRIO_HIGH);
  assign wr_latch = wr_low && (paddr == `UCC_OFF_PORT_LATCH);
  assign wr_dir = wr_low && (paddr == `UCC_OFF_PORT_DIR);
  assign wr_start = wr_low && (paddr == `UCC_OFF_CHAN_START);
  assign wr_request = wr_low && (paddr == `UCC_OFF_IRQ_REQUEST);
  assign wr_evt_mask = wr_low && (paddr == `UCC_OFF_EVT_MASK);

  ////////////////////////////////////////////////////////////////////////////////
  // plain storage registers
  reg [7:0] irq_mask_reg;
  reg [7:0] irq_prio_low_reg;
  reg [7:0] irq_prio_high_reg;
  reg [7:0] port_one_latch;
  reg [7:0] port_one_dir;
  reg [7:0] evt_mask;

  // software-written control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= `UCC_RST_IRQ_MASK;
      irq_prio_low_reg <= `UCC_RST_PRIO;
      irq_prio_high_reg <= `UCC_RST_PRIO;
      port_one_latch <= `UCC_RST_PORT_LATCH;
      port_one_dir <= `UCC_RST_PORT_DIR;
      evt_mask <= `UCC_RST_EVT_MASK;
    end else begin
      if (wr_mask) begin
        irq_mask_reg <= pwdata[7:0];
      end
      if (wr_prio_lo) begin
        irq_prio_low_reg <= pwdata[7:0];
      end
      if (wr_prio_hi) begin
        irq_prio_high_reg <= pwdata[7:0];
      end
      if (wr_latch) begin
        port_one_latch <= pwdata[7:0];
      end
      if (wr_dir) begin
        port_one_dir <= pwdata[7:0];
      end
      if (wr_evt_mask) begin
        evt_mask <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive error flags: event sets, clear trigger clears, set wins
  wire [2:0] rx_err_flags;
  wire [2:0] err_set;
  wire [2:0] err_clr;
  wire framing_err_flag;
  wire parity_err_flag;
  wire overrun_err_flag;
  wire framing_err_clear_trig;
  wire parity_err_clear_trig;
  wire overrun_err_clear_trig;
  assign err_set = {framing_err_event, parity_err_event, overrun_err_event};
  assign err_clr = wr_clear ? pwdata[2:0] : 3'h0;
  assign framing_err_clear_trig = err_clr[`UCC_BIT_FRAMING];
  assign parity_err_clear_trig = err_clr[`UCC_BIT_PARITY];
  assign overrun_err_clear_trig = err_clr[`UCC_BIT_OVERRUN];

  // framing error flag, dropped by clear trigger bit 2
  ucc_sticky #(.W(1)) framing_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(err_set[`UCC_BIT_FRAMING]),
    .clr(framing_err_clear_trig),
    .flag(framing_err_flag)
  );

  // parity error flag, dropped by clear trigger bit 1
  ucc_sticky #(.W(1)) parity_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(err_set[`UCC_BIT_PARITY]),
    .clr(parity_err_clear_trig),
    .flag(parity_err_flag)
  );

  // overrun error flag, dropped by clear trigger bit 0
  ucc_sticky #(.W(1)) overrun_flag (
    .pclk(pclk),
    .presetn(presetn),
    .set(err_set[`UCC_BIT_OVERRUN]),
    .clr(overrun_err_clear_trig),
    .flag(overrun_err_flag)
  );

  // error status word in its register layout
  assign rx_err_flags[`UCC_BIT_FRAMING] = framing_err_flag;
  assign rx_err_flags[`UCC_BIT_PARITY] = parity_err_flag;
  assign rx_err_flags[`UCC_BIT_OVERRUN] = overrun_err_flag;

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt request flags: source sets, software write replaces, set wins
  reg [2:0] irq_request;
  wire [2:0] src_set;
  wire rx_error_any;
  assign rx_error_any = framing_err_event | parity_err_event | overrun_err_event;
  assign src_set = {rx_error_any, rx_end_event, tx_end_event};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request <= 3'h0;
    end else if (wr_request) begin
      irq_request <= pwdata[2:0] | src_set;
    end else begin
      irq_request <= irq_request | src_set;
    end
  end

  // per-source request and mask bits
  wire tx_end_irq_request;
  wire rx_end_irq_request;
  wire rx_error_irq_request;
  wire tx_end_irq_mask;
  wire rx_end_irq_mask;
  wire rx_error_irq_mask;
  assign tx_end_irq_request = irq_request[`UCC_BIT_TX_END];
  assign rx_end_irq_request = irq_request[`UCC_BIT_RX_END];
  assign rx_error_irq_request = irq_request[`UCC_BIT_RX_ERROR];
  assign tx_end_irq_mask = irq_mask_reg[`UCC_BIT_TX_END];
  assign rx_end_irq_mask = irq_mask_reg[`UCC_BIT_RX_END];
  assign rx_error_irq_mask = irq_mask_reg[`UCC_BIT_RX_ERROR];

  // unmasked pending sources and the best priority among them
  wire [2:0] pending;
  wire [1:0] prio_tx;
  wire [1:0] prio_rx;
  wire [1:0] prio_er;
  assign pending[`UCC_BIT_TX_END] = tx_end_irq_request & ~tx_end_irq_mask;
  assign pending[`UCC_BIT_RX_END] = rx_end_irq_request & ~rx_end_irq_mask;
  assign pending[`UCC_BIT_RX_ERROR] = rx_error_irq_request & ~rx_error_irq_mask;
  assign prio_tx = {irq_prio_high_reg[`UCC_BIT_TX_END], irq_prio_low_reg[`UCC_BIT_TX_END]};
  assign prio_rx = {irq_prio_high_reg[`UCC_BIT_RX_END], irq_prio_low_reg[`UCC_BIT_RX_END]};
  assign prio_er = {irq_prio_high_reg[`UCC_BIT_RX_ERROR], irq_prio_low_reg[`UCC_BIT_RX_ERROR]};

  // lowest level number wins among pending sources
  reg [1:0] best_level;
  always @* begin
    best_level = 2'h3;
    if (pending[`UCC_BIT_TX_END] && (prio_tx < best_level)) begin
      best_level = prio_tx;
    end
    if (pending[`UCC_BIT_RX_END] && (prio_rx < best_level)) begin
      best_level = prio_rx;
    end
    if (pending[`UCC_BIT_RX_ERROR] && (prio_er < best_level)) begin
      best_level = prio_er;
    end
  end
  assign irq_level = best_level;
  assign irq_level_valid = |pending;

  ////////////////////////////////////////////////////////////////////////////////
  // channel start: write of 1 enables channel, 0 leaves it
  wire [3:0] chan_enabled;
  wire [3:0] chan_start_set;
  reg [3:0] start_pulse;
  assign chan_start_set = wr_start ? pwdata[3:0] : 4'h0;

  // enabled status per channel; nothing in this slice stops a channel
  ucc_sticky #(.W(4)) chan_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(chan_start_set),
    .clr(4'h0),
    .flag(chan_enabled)
  );

  // one-cycle start pulse toward the shift engine
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_pulse <= 4'h0;
    end else begin
      start_pulse <= chan_start_set;
    end
  end
  assign channel_enabled_status = chan_enabled;
  assign channel_start_pulse = start_pulse;

  ////////////////////////////////////////////////////////////////////////////////
  // sticky event status, cleared by read, masked onto one irq line
  wire [7:0] evt_status;
  wire [7:0] evt_in;
  wire [7:0] evt_clr;
  wire rd_evt;
  assign evt_in = {3'h0, err_set, src_set[`UCC_BIT_RX_END], src_set[`UCC_BIT_TX_END]};
  assign rd_evt = rd_en && (paddr == `UCC_OFF_EVT_STATUS);
  // a read drops only the bits it returned, so an event after the setup cycle waits
  assign evt_clr = rd_evt ? prdata[7:0] : 8'h00;

  // sticky event bits
  ucc_sticky #(.W(8)) evt_flags (
    .pclk(pclk),
    .presetn(presetn),
    .set(evt_in),
    .clr(evt_clr),
    .flag(evt_status)
  );
  assign irq_out = |(evt_status & evt_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // port one pins: enable flops follow every direction write, high while driving
  reg [7:0] pin_oe_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_q <= ~`UCC_RST_PORT_DIR;
    end else if (wr_dir) begin
      pin_oe_q <= ~pwdata[7:0];
    end
  end
  assign port_one_pin_oe = pin_oe_q;
  assign port_one_pin_out = port_one_latch;

  // two-stage synchroniser for the pin levels
  reg [7:0] pin_meta;
  reg [7:0] pin_sync;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= port_one_pin_in;
      pin_sync <= pin_meta;
    end
  end
  assign port_one_pin_sync = pin_sync;

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, registered in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `UCC_OFF_FLAG_CLEAR) begin
        prdata <= 32'h00000000; // clear triggers read back as 0
      end else if (paddr == `UCC_OFF_CHAN_START) begin
        prdata <= 32'h00000000; // start triggers read back as 0
      end else if (paddr == `UCC_OFF_IRQ_MASK) begin
        prdata <= {24'h000000, irq_mask_reg};
      end else if (paddr == `UCC_OFF_PRIO_LOW) begin
        prdata <= {24'h000000, irq_prio_low_reg};
      end else if (paddr == `UCC_OFF_PRIO_HIGH) begin
        prdata <= {24'h000000, irq_prio_high_reg};
      end else if (paddr == `UCC_OFF_PORT_LATCH) begin
        prdata <= {24'h000000, port_one_latch};
      end else if (paddr == `UCC_OFF_PORT_DIR) begin
        prdata <= {24'h000000, port_one_dir};
      end else if (paddr == `UCC_OFF_IRQ_REQUEST) begin
        prdata <= {29'h00000000, irq_request};
      end else if (paddr == `UCC_OFF_RX_STATUS) begin
        prdata <= {29'h00000000, rx_err_flags};
      end else if (paddr == `UCC_OFF_CHAN_ENABLED) begin
        prdata <= {28'h0000000, chan_enabled};
      end else if (paddr == `UCC_OFF_EVT_STATUS) begin
        prdata <= {24'h000000, evt_status};
      end else if (paddr == `UCC_OFF_EVT_MASK) begin
        prdata <= {24'h000000, evt_mask};
      end else begin
        prdata <= 32'h00000000; // unmapped addresses read 0
      end
    end
  end

endmodule
`default_nettype wire

/* File: ucc_top_bench.sv */
// self-checking bench of ucc_top over apb
// assumes ucc_chk and ucc_remote compiled first
`timescale 1ns/100ps
`default_nettype none
module ucc_top_bench;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hf;
  logic [4:0] ev = 0;
  logic [31:0] prdata;
  logic [7:0] pin_out, pin_oe, pin_in, pin_sync;
  logic [3:0] en;
  logic [1:0] lvl;
  logic pready, pslverr, irq, lv, err;
  integer bad_count = 0;
  integer checked = 0;
  always #50 pclk = ~pclk;
  ucc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .framing_err_event(ev[4]), .parity_err_event(ev[3]), .overrun_err_event(ev[2]),
    .rx_end_event(ev[1]), .tx_end_event(ev[0]), .port_one_pin_in(pin_in), .port_one_pin_out(pin_out),
    .port_one_pin_oe(pin_oe), .port_one_pin_sync(pin_sync), .channel_enabled_status(en),
    .channel_start_pulse(), .irq_out(irq), .irq_level(lvl), .irq_level_valid(lv));
  ucc_remote far (.pclk, .pin_out, .pin_oe, .pin_in);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    integer n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      final_report;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #10;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk("read", r, exp);
  endtask
  // one-cycle event pulses
  task automatic pulse(input logic [4:0] e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= 5'h0;
    #10;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(12'h004, 32'hff);
    rd(12'h008, 32'hff);
    rd(12'h010, 32'h00);
    rd(12'h014, 32'hff);
    chk("oe", pin_oe, 8'h00);
    rd(12'h030, 32'h0);
    chk("slverr", err, 1'b1);
    @(posedge pclk);
    pstrb <= 4'he;
    wr(12'h004, 32'h00);
    @(posedge pclk);
    pstrb <= 4'hf;
    rd(12'h004, 32'hff);
  endtask
  task automatic t_errors;
    pulse(5'h1c);
    rd(12'h020, 32'h7);
    wr(12'h000, 32'h2);
    rd(12'h020, 32'h5);
    wr(12'h000, 32'h0);
    rd(12'h020, 32'h5);
    wr(12'h000, 32'h4);
    rd(12'h020, 32'h1);
    wr(12'h000, 32'h1);
    rd(12'h020, 32'h0);
    rd(12'h000, 32'h0);
  endtask
  task automatic t_irq;
    wr(12'h01c, 32'h0);
    wr(12'h004, 32'hfe);
    pulse(5'h01);
    rd(12'h01c, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(12'h008, {31'h7f, i[0]});
      wr(12'h00c, {31'h7f, i[1]});
      chk("level", {lv, lvl}, {1'b1, i[1:0]});
    end
    wr(12'h004, 32'hff);
    chk("valid", lv, 1'b0);
    wr(12'h01c, 32'h0);
    rd(12'h01c, 32'h0);
  endtask
  task automatic t_evt;
    logic [31:0] r;
    apb(1'b0, 12'h028, 32'h0, r);
    wr(12'h02c, 32'h1);
    pulse(5'h01);
    chk("irq", irq, 1'b1);
    rd(12'h028, 32'h1);
    chk("irq", irq, 1'b0);
    wr(12'h02c, 32'h0);
    pulse(5'h01);
    chk("irq", irq, 1'b0);
    rd(12'h028, 32'h1);
  endtask
  task automatic t_start;
    repeat (4) @(posedge pclk);
    wr(12'h018, 32'h5);
    chk("en", en, 4'h5);
    wr(12'h018, 32'h0);
    chk("en", en, 4'h5);
    wr(12'h018, 32'ha);
    chk("en", en, 4'hf);
    rd(12'h018, 32'h0);
  endtask
  task automatic t_port;
    wr(12'h010, 32'h04);
    wr(12'h014, 32'hfb);
    chk("oe", pin_oe, 8'h04);
    chk("out", pin_out[2], 1'b1);
    wr(12'h010, 32'h00);
    chk("out", pin_out[2], 1'b0);
    repeat (6) @(posedge pclk);
    chk("sync", pin_sync, 8'hf9);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_errors;
    t_irq;
    t_evt;
    t_start;
    t_port;
    final_report;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    final_report;
  end
endmodule
bind ucc_top ucc_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
  .framing_err_event, .port_one_pin_out, .port_one_pin_oe, .channel_enabled_status, .channel_start_pulse,
  .irq_level, .irq_level_valid);
`default_nettype wire
